// ===== hw/brake_pkg.sv
// Purpose: constants for the motor brake sequencer
// Assumes: 100 MHz clock, 10 ms timing tick
// Notes: register offsets are word byte addresses on classic Wishbone
package brake_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_MS = 10;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_SON_DLY = 4'h4;
    localparam logic [3:0] ADDR_SOFF_DLY = 4'h8;
    localparam logic [3:0] ADDR_STBY = 4'hC;
    localparam logic [3:0] ADDR_SPD = 4'h0;
    localparam logic [3:0] ADDR_STAT = 4'h4;
    localparam logic [1:0] PAGE_TIME = 2'h0;
    localparam logic [1:0] PAGE_MISC = 2'h1;
    localparam logic [10:0] SETTING_MAX = 11'h3E8;
    localparam logic [10:0] SON_DLY_RST = 11'h000;
    localparam logic [10:0] SOFF_DLY_RST = 11'h000;
    localparam logic [10:0] STBY_RST = 11'h000;
    localparam logic [10:0] SPD_RST = 11'h064;
    localparam logic [2:0] CHAN_RST = 3'h2;
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_ON_HOLD = 2'b01,
        ST_RUN = 2'b10,
        ST_STOPPING = 2'b11
    } seq_state_t;
endpackage

// ===== hw/motor_brake_sequencer.sv
// Purpose: servo-on/off and holding brake sequencing with Wishbone settings
// Assumes: servo_on_command_i and motor_speed_i come from another domain
// Notes: output high on a channel means brake released (relay energised)
`timescale 1ns/10ps
// Behaviour
// - brake drives assigned output channel, default third
// - delay brake release after servo-on, 0-1000 ticks
// - servo-on reached first, brake released later
// - servo-off delayed programmable 0-1000 ticks
// - brake engages after standby time from command
// - brake engages when speed at or below threshold
// - whichever of time or speed comes first
// - settings writable only while servo off
module motor_brake_sequencer #(
    parameter int TICK_CYCLES = brake_pkg::TICK_CYCLES,
    parameter int NUM_OUT = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic servo_on_command_i,
    input wire logic [10:0] motor_speed_i,
    output logic servo_enable_o,
    output logic [NUM_OUT-1:0] seq_out_o
);
    // ========================================
    // input synchronisers
    logic [1:0] cmd_sync_q;
    logic [10:0] spd_meta_q;
    logic [10:0] spd_q;
    always_ff @(posedge clk_i)
    begin
        cmd_sync_q <= {cmd_sync_q[0], servo_on_command_i};
        spd_meta_q <= motor_speed_i;
        spd_q <= spd_meta_q;
    end
    wire cmd_on = cmd_sync_q[1];

    // ========================================
    // settings and bus
    logic [10:0] son_dly_q;
    logic [10:0] soff_dly_q;
    logic [10:0] stby_q;
    logic [10:0] spd_thr_q;
    logic [2:0] chan_q;
    logic rejected_q;
    brake_pkg::seq_state_t state_q;
    logic brake_release_q;
    wire acc = cyc_i && stb_i && !ack_o;
    // writes land at the ack edge, the one edge at which the master samples the answer
    wire wr = cyc_i && stb_i && ack_o && we_i && sel_i[0] && sel_i[1];
    wire [1:0] page = adr_i[5:4];
    wire [3:0] off = adr_i[3:0];
    wire is_setting = (page == brake_pkg::PAGE_TIME && off != brake_pkg::ADDR_CTRL)
                      || (page == brake_pkg::PAGE_MISC && off == brake_pkg::ADDR_SPD);
    wire locked = state_q != brake_pkg::ST_OFF;
    wire [10:0] wval = (dat_i[10:0] > brake_pkg::SETTING_MAX) ? brake_pkg::SETTING_MAX : dat_i[10:0];

    // settings change only while servo off; out of range writes clamp
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            son_dly_q <= brake_pkg::SON_DLY_RST;
            soff_dly_q <= brake_pkg::SOFF_DLY_RST;
            stby_q <= brake_pkg::STBY_RST;
            spd_thr_q <= brake_pkg::SPD_RST;
            chan_q <= brake_pkg::CHAN_RST;
            rejected_q <= 1'b0;
        end
        else if (wr && is_setting && locked)
        begin
            rejected_q <= 1'b1;
        end
        else if (wr && !locked)
        begin
            if (page == brake_pkg::PAGE_TIME && off == brake_pkg::ADDR_SON_DLY)
                son_dly_q <= wval;
            if (page == brake_pkg::PAGE_TIME && off == brake_pkg::ADDR_SOFF_DLY)
                soff_dly_q <= wval;
            if (page == brake_pkg::PAGE_TIME && off == brake_pkg::ADDR_STBY)
                stby_q <= wval;
            if (page == brake_pkg::PAGE_MISC && off == brake_pkg::ADDR_SPD)
                spd_thr_q <= wval;
            if (page == brake_pkg::PAGE_TIME && off == brake_pkg::ADDR_CTRL)
            begin
                chan_q <= dat_i[2:0];
                if (dat_i[8])
                    rejected_q <= 1'b0;
            end
        end
        else if (wr && page == brake_pkg::PAGE_TIME && off == brake_pkg::ADDR_CTRL)
        begin
            if (dat_i[8])
                rejected_q <= 1'b0;
        end
    end

    // one-wait-state slave: ack one cycle after request, unmapped reads zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end
        else
        begin
            ack_o <= acc;
            dat_o <= 32'h0000_0000;
            if (acc && !we_i)
            begin
                case ({page, off})
                    {brake_pkg::PAGE_TIME, brake_pkg::ADDR_CTRL}: dat_o <= {23'h0, rejected_q, 5'h0, chan_q};
                    {brake_pkg::PAGE_TIME, brake_pkg::ADDR_SON_DLY}: dat_o <= {21'h0, son_dly_q};
                    {brake_pkg::PAGE_TIME, brake_pkg::ADDR_SOFF_DLY}: dat_o <= {21'h0, soff_dly_q};
                    {brake_pkg::PAGE_TIME, brake_pkg::ADDR_STBY}: dat_o <= {21'h0, stby_q};
                    {brake_pkg::PAGE_MISC, brake_pkg::ADDR_SPD}: dat_o <= {21'h0, spd_thr_q};
                    {brake_pkg::PAGE_MISC, brake_pkg::ADDR_STAT}:
                        dat_o <= {28'h0, brake_release_q, servo_enable_o, state_q};
                    default: dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ========================================
    // 10 ms tick
    logic [$clog2(TICK_CYCLES)-1:0] pre_q;
    logic tick_q;
    always_ff @(posedge clk_i)
    begin
        if (rst_i || pre_q == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1))
            pre_q <= '0;
        else
            pre_q <= pre_q + 1'b1;
        tick_q <= !rst_i && pre_q == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1);
    end

    // ========================================
    // sequencer: counters count 10 ms ticks from entry to a state
    logic [10:0] t_on_q;
    logic [10:0] t_off_q;
    wire spd_low = spd_q <= spd_thr_q;
    wire stby_done = t_off_q >= stby_q;
    // servo drops at this edge; the pin must drop with it, not one cycle later
    wire off_now = state_q == brake_pkg::ST_STOPPING && t_off_q >= soff_dly_q;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q <= brake_pkg::ST_OFF;
            servo_enable_o <= 1'b0;
            brake_release_q <= 1'b0;
            t_on_q <= 11'h000;
            t_off_q <= 11'h000;
        end
        else
        begin
            case (state_q)
                brake_pkg::ST_OFF:
                begin
                    brake_release_q <= 1'b0;
                    t_on_q <= 11'h000;
                    if (cmd_on)
                    begin
                        state_q <= brake_pkg::ST_ON_HOLD;
                        servo_enable_o <= 1'b1;
                    end
                end
                brake_pkg::ST_ON_HOLD:
                begin
                    if (!cmd_on)
                    begin
                        state_q <= brake_pkg::ST_STOPPING;
                        t_off_q <= 11'h000;
                    end
                    else if (t_on_q >= son_dly_q)
                    begin
                        state_q <= brake_pkg::ST_RUN;
                        brake_release_q <= 1'b1;
                    end
                    else if (tick_q)
                        t_on_q <= t_on_q + 11'h001;
                end
                brake_pkg::ST_RUN:
                begin
                    if (!cmd_on)
                    begin
                        state_q <= brake_pkg::ST_STOPPING;
                        t_off_q <= 11'h000;
                    end
                end
                brake_pkg::ST_STOPPING:
                begin
                    if (stby_done || spd_low)
                        brake_release_q <= 1'b0;
                    if (t_off_q >= soff_dly_q)
                    begin
                        state_q <= brake_pkg::ST_OFF;
                        servo_enable_o <= 1'b0;
                        brake_release_q <= 1'b0;
                    end
                    else if (tick_q)
                        t_off_q <= t_off_q + 11'h001;
                end
                default: state_q <= brake_pkg::ST_OFF;
            endcase
        end
    end

    // ========================================
    // channel routing: only the assigned channel carries the brake signal
    always_ff @(posedge clk_i)
    begin
        for (int i = 0; i < NUM_OUT; i++)
            seq_out_o[i] <= !rst_i && brake_release_q && !off_now && (chan_q == 3'(i));
    end

    // ========================================
    // checks
    property p_brake_needs_servo;
        @(posedge clk_i) disable iff (rst_i) brake_release_q |-> servo_enable_o;
    endproperty
    a_brake_needs_servo: assert property (p_brake_needs_servo) else $error("brake released without servo");
    property p_off_engaged;
        @(posedge clk_i) disable iff (rst_i) !servo_enable_o |-> !brake_release_q;
    endproperty
    a_off_engaged: assert property (p_off_engaged) else $error("brake not engaged in servo off");
    property p_pins_engaged;
        @(posedge clk_i) disable iff (rst_i) !servo_enable_o |-> seq_out_o == '0;
    endproperty
    a_pins_engaged: assert property (p_pins_engaged) else $error("brake output open in servo off");
    property p_release_after_delay;
        @(posedge clk_i) disable iff (rst_i) $rose(brake_release_q) |-> $past(t_on_q) >= son_dly_q;
    endproperty
    a_release_after_delay: assert property (p_release_after_delay) else $error("brake released early");
    property p_servo_first;
        @(posedge clk_i) disable iff (rst_i) $rose(servo_enable_o) |-> !brake_release_q;
    endproperty
    a_servo_first: assert property (p_servo_first) else $error("release with servo-on edge");
    property p_off_delay;
        @(posedge clk_i) disable iff (rst_i) $fell(servo_enable_o) |-> $past(t_off_q) >= soff_dly_q;
    endproperty
    a_off_delay: assert property (p_off_delay) else $error("servo off too early");
    property p_stby_engage;
        @(posedge clk_i) disable iff (rst_i) state_q == brake_pkg::ST_STOPPING && stby_done |=> !brake_release_q;
    endproperty
    a_stby_engage: assert property (p_stby_engage) else $error("standby expired, brake open");
    property p_speed_engage;
        @(posedge clk_i) disable iff (rst_i) state_q == brake_pkg::ST_STOPPING && spd_low |=> !brake_release_q;
    endproperty
    a_speed_engage: assert property (p_speed_engage) else $error("speed low, brake open");
    property p_locked;
        @(posedge clk_i) disable iff (rst_i) locked && wr |=> $stable(son_dly_q) && $stable(stby_q)
            && $stable(soff_dly_q) && $stable(spd_thr_q);
    endproperty
    a_locked: assert property (p_locked) else $error("setting changed while servo on");
    property p_channel;
        @(posedge clk_i) disable iff (rst_i) ##1 seq_out_o[brake_pkg::CHAN_RST] != $past(brake_release_q && !off_now)
            |-> $past(chan_q) != brake_pkg::CHAN_RST;
    endproperty
    a_channel: assert property (p_channel) else $error("brake not on assigned channel");
    c_run: cover property (@(posedge clk_i) disable iff (rst_i) state_q == brake_pkg::ST_RUN);
    c_stop: cover property (@(posedge clk_i) disable iff (rst_i) $fell(servo_enable_o));
    c_reject: cover property (@(posedge clk_i) disable iff (rst_i) $rose(rejected_q));
endmodule

// ===== bench/host_model.sv
// Purpose: host controller side of the brake sequencer
// Assumes: one clock, command and speed change only at rising edges
// Notes: with slow_i set, speed falls to a slow creep only once the command is off
`timescale 1ns/10ps
module host_model (
    input wire logic clk_i,
    input wire logic on_i,
    input wire logic slow_i,
    input wire logic [10:0] fast_i,
    output logic servo_on_command_o = 1'b0,
    output logic [10:0] motor_speed_o = 11'h000
);
    // ============================================================
    // command and speed
    // the command is a plain level; speed stays put between changes so the
    // per-bit synchroniser never sees a torn value
    always_ff @(posedge clk_i)
    begin
        servo_on_command_o <= on_i;
        motor_speed_o <= (slow_i && !on_i) ? 11'h01E : fast_i;
    end
endmodule

// ===== bench/tb.sv
// Purpose: self-checking bench for the motor brake sequencer
// Assumes: tick shortened to 10 cycles, host model on the command side
// Notes: read results go through a queue to a watching process
`timescale 1ns/10ps
module tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, on = 1'b0, slow = 1'b0;
    logic ack, en, cmd;
    logic [5:0] adr = 6'h00;
    logic [31:0] dat = 32'h0, rdat, rnd = 32'h24;
    logic [10:0] fast = 11'h3E8, spd;
    logic [7:0] seq;
    logic [31:0] expq[$];
    int errors = 0, checks_done = 0, ch = 2, te, tk;
    always #5 clk_i = ~clk_i;
    host_model host_model_i (.clk_i(clk_i), .on_i(on), .slow_i(slow), .fast_i(fast),
        .servo_on_command_o(cmd), .motor_speed_o(spd));
    motor_brake_sequencer #(.TICK_CYCLES(10)) motor_brake_sequencer_i (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(rdat),
        .ack_o(ack), .servo_on_command_i(cmd), .motor_speed_i(spd), .servo_enable_o(en), .seq_out_o(seq));
    // ============================================================
    // helpers
    task automatic end_sim();
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rng(input int v, input int lo, input int hi);
        chk({31'h0, v >= lo && v <= hi}, 32'h1);
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // one classic cycle; d is write data, or the expected data of a read
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        if (!w)
            expq.push_back(d);
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            errors++;
            end_sim();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // cycles until enable and brake output reach lvl; bounded, a hang fails
    task automatic watch(input logic lvl);
        int n;
        n = 0;
        te = -1;
        tk = -1;
        while ((te < 0 || tk < 0) && n < 400)
        begin
            @(posedge clk_i);
            n++;
            if (te < 0 && en === lvl)
                te = n;
            if (tk < 0 && seq[ch] === lvl)
                tk = n;
        end
        if (n >= 400)
        begin
            errors++;
            end_sim();
        end
    endtask
    // ============================================================
    // read data watcher: oldest note against data at the ack edge
    always @(posedge clk_i)
    begin
        if (ack === 1'b1 && we === 1'b0 && expq.size() > 0)
            chk(rdat, expq.pop_front());
    end
    // ============================================================
    // main sequence; run 0 on the default channel, run 1 on channel 5 with a slow motor
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        chk({24'h0, seq}, 32'h0);
        bus(1'b0, 6'h00, 32'h2);
        bus(1'b0, 6'h10, 32'h64);
        bus(1'b0, 6'h14, 32'h0);
        bus(1'b0, 6'h20, 32'h0);
        bus(1'b1, 6'h04, 32'h7D0);
        bus(1'b0, 6'h04, 32'h3E8);
        bus(1'b1, 6'h04, 32'h5);
        bus(1'b1, 6'h08, 32'h14);
        bus(1'b1, 6'h0C, 32'h8);
        bus(1'b1, 6'h10, 32'h32);
        for (int r = 0; r < 2; r++)
        begin
            rnd = xs(rnd);
            fast <= 11'(rnd % 950 + 51);
            slow <= (r == 1);
            on <= 1'b1;
            watch(1'b1);
            chk({24'h0, seq}, 32'h1 << ch);
            rng(te, 1, 8);
            rng(tk - te, 39, 52);
            bus(1'b1, 6'h04, 32'h0);
            bus(1'b0, 6'h04, 32'h5);
            bus(1'b0, 6'h14, 32'hE);
            bus(1'b0, 6'h00, 32'h100 | ch);
            on <= 1'b0;
            watch(1'b0);
            chk({24'h0, seq}, 32'h0);
            rng(te, 190, 206);
            rng(tk, r ? 1 : 78, r ? 12 : 87);
            bus(1'b1, 6'h00, 32'h105);
            bus(1'b0, 6'h00, 32'h5);
            ch = 5;
        end
        end_sim();
    end
endmodule
